// >>> rtl/disp_port_pkg.sv
// Purpose: Constants shared by the display serial host port
// Assumes: Byte-kind selector high marks data, low marks command
// Notes:   Bit count and reset values for the receive path
package disp_port_pkg;
   localparam int unsigned BYTE_BITS      = 8;
   localparam logic [2:0]  BIT_CNT_RST    = 3'h0;
   localparam logic [2:0]  BIT_CNT_LAST   = 3'h7;
   localparam logic [7:0]  BYTE_RST       = 8'h00;
   localparam logic        KIND_DATA      = 1'b1;
   localparam logic        KIND_COMMAND   = 1'b0;
   localparam logic [1:0]  SYNC_RST       = 2'h0;
   localparam logic [1:0]  SYNC_SEL_RST   = 2'h3;
endpackage

// >>> rtl/display_serial_host_port.sv
// Purpose: Serial receive port of a dot-matrix display controller
// Assumes: mclk_i well above the link clock; all pins are asynchronous to mclk_i
// Notes:   Pins pass two flip-flops; link clock edges found on mclk_i
//
// Function
// - Select low with two-wire mode off: accept host traffic
// - Select high: ignore clock and data lines, bit count cleared
// - Init input low: initialize controller logic
// - Selector high: byte goes to data register
// - Selector low: byte goes to command register
// - Two-wire mode: selector is address bit zero
// - Data on bus line one, clock line zero
`timescale 1ns/1ps
module display_serial_host_port
(
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   input  wire logic       init_pulse_n_i,
   input  wire logic       select_n_i,
   input  wire logic       data_cmd_i,
   input  wire logic       bus_line_zero_i,
   input  wire logic       bus_line_one_i,
   input  wire logic       two_wire_mode_i,
   output logic [7:0]      data_reg_o,
   output logic            data_strobe_o,
   output logic [7:0]      command_reg_o,
   output logic            command_strobe_o,
   output logic            target_addr_lsb_o,
   output logic            init_active_o
);
   import disp_port_pkg::*;

   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic [1:0] sck_sync_r, sdi_sync_r, sel_sync_r, dc_sync_r, init_sync_r, mode_sync_r;
   logic       sck_prev_r, sck_prev_nxt;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] data_reg_r, data_reg_nxt, cmd_reg_r, cmd_reg_nxt;
   logic       data_stb_r, data_stb_nxt, cmd_stb_r, cmd_stb_nxt;
   logic       addr_lsb_r, addr_lsb_nxt, init_r, init_nxt;
   logic       sck_rise, selected, init_now;

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rst_sync_r <= SYNC_RST;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_sync_r  <= SYNC_RST;
         sdi_sync_r  <= SYNC_RST;
         sel_sync_r  <= SYNC_SEL_RST;
         dc_sync_r   <= SYNC_RST;
         init_sync_r <= SYNC_SEL_RST;
         mode_sync_r <= SYNC_RST;
      end
      else
      begin
         sck_sync_r  <= {sck_sync_r[0], bus_line_zero_i};
         sdi_sync_r  <= {sdi_sync_r[0], bus_line_one_i};
         sel_sync_r  <= {sel_sync_r[0], select_n_i};
         dc_sync_r   <= {dc_sync_r[0], data_cmd_i};
         init_sync_r <= {init_sync_r[0], init_pulse_n_i};
         mode_sync_r <= {mode_sync_r[0], two_wire_mode_i};
      end
   end

   assign selected = !sel_sync_r[1] && !mode_sync_r[1];
   assign init_now = !init_sync_r[1];
   assign sck_rise = sck_sync_r[1] && !sck_prev_r;

   always_comb
   begin
      sck_prev_nxt = sck_sync_r[1];
      bit_cnt_nxt  = bit_cnt_r;
      shift_nxt    = shift_r;
      data_reg_nxt = data_reg_r;
      cmd_reg_nxt  = cmd_reg_r;
      data_stb_nxt = 1'b0;
      cmd_stb_nxt  = 1'b0;
      init_nxt     = init_now;
      addr_lsb_nxt = mode_sync_r[1] ? dc_sync_r[1] : addr_lsb_r;
      if (init_now)
      begin
         bit_cnt_nxt  = BIT_CNT_RST;
         shift_nxt    = BYTE_RST;
         data_reg_nxt = BYTE_RST;
         cmd_reg_nxt  = BYTE_RST;
      end
      else if (!selected)
         bit_cnt_nxt = BIT_CNT_RST;
      else if (sck_rise)
      begin
         shift_nxt   = {shift_r[6:0], sdi_sync_r[1]};
         bit_cnt_nxt = bit_cnt_r + 3'h1;
         if (bit_cnt_r == BIT_CNT_LAST)
         begin
            if (dc_sync_r[1] == KIND_DATA)
            begin
               data_reg_nxt = {shift_r[6:0], sdi_sync_r[1]};
               data_stb_nxt = 1'b1;
            end
            else
            begin
               cmd_reg_nxt = {shift_r[6:0], sdi_sync_r[1]};
               cmd_stb_nxt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_prev_r <= 1'b0;
         bit_cnt_r  <= BIT_CNT_RST;
         shift_r    <= BYTE_RST;
         data_reg_r <= BYTE_RST;
         cmd_reg_r  <= BYTE_RST;
         data_stb_r <= 1'b0;
         cmd_stb_r  <= 1'b0;
         addr_lsb_r <= 1'b0;
         init_r     <= 1'b0;
      end
      else
      begin
         sck_prev_r <= sck_prev_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         shift_r    <= shift_nxt;
         data_reg_r <= data_reg_nxt;
         cmd_reg_r  <= cmd_reg_nxt;
         data_stb_r <= data_stb_nxt;
         cmd_stb_r  <= cmd_stb_nxt;
         addr_lsb_r <= addr_lsb_nxt;
         init_r     <= init_nxt;
      end
   end

   assign data_reg_o        = data_reg_r;
   assign data_strobe_o     = data_stb_r;
   assign command_reg_o     = cmd_reg_r;
   assign command_strobe_o  = cmd_stb_r;
   assign target_addr_lsb_o = addr_lsb_r;
   assign init_active_o     = init_r;

   property p_no_strobe_unselected;
      @(posedge mclk_i) disable iff (!rst_n)
      !selected |=> !data_stb_r && !cmd_stb_r;
   endproperty
   a_no_strobe_unselected: assert property (p_no_strobe_unselected) else $error("strobe while unselected");

   property p_init_clears;
      @(posedge mclk_i) disable iff (!rst_n)
      init_now |=> data_reg_r == BYTE_RST && cmd_reg_r == BYTE_RST && bit_cnt_r == BIT_CNT_RST;
   endproperty
   a_init_clears: assert property (p_init_clears) else $error("init did not clear");

   property p_data_kind;
      @(posedge mclk_i) disable iff (!rst_n)
      selected && !init_now && sck_rise && bit_cnt_r == BIT_CNT_LAST && dc_sync_r[1]
         |=> data_stb_r && !cmd_stb_r && data_reg_r == $past(shift_nxt);
   endproperty
   a_data_kind: assert property (p_data_kind) else $error("data byte misrouted");

   property p_cmd_kind;
      @(posedge mclk_i) disable iff (!rst_n)
      selected && !init_now && sck_rise && bit_cnt_r == BIT_CNT_LAST && !dc_sync_r[1]
         |=> cmd_stb_r && !data_stb_r;
   endproperty
   a_cmd_kind: assert property (p_cmd_kind) else $error("command byte misrouted");

   property p_addr_lsb;
      @(posedge mclk_i) disable iff (!rst_n)
      mode_sync_r[1] |=> target_addr_lsb_o == $past(dc_sync_r[1]);
   endproperty
   a_addr_lsb: assert property (p_addr_lsb) else $error("address bit wrong");

   property p_shift_in;
      @(posedge mclk_i) disable iff (!rst_n)
      selected && !init_now && sck_rise |=> shift_r[0] == $past(sdi_sync_r[1]);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("bit not shifted in");

   property p_count_step;
      @(posedge mclk_i) disable iff (!rst_n)
      selected && !init_now && sck_rise |=> bit_cnt_r == $past(bit_cnt_r) + 3'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("bit count step");

   property p_strobe_single;
      @(posedge mclk_i) disable iff (!rst_n)
      data_stb_r || cmd_stb_r |=> !data_stb_r && !cmd_stb_r;
   endproperty
   a_strobe_single: assert property (p_strobe_single) else $error("strobe too long");

   property p_data_hold;
      @(posedge mclk_i) disable iff (!rst_n)
      !init_now && !(selected && sck_rise && bit_cnt_r == BIT_CNT_LAST && dc_sync_r[1] == KIND_DATA)
         |=> $stable(data_reg_r);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data register changed without a byte");

   property p_cmd_hold;
      @(posedge mclk_i) disable iff (!rst_n)
      !init_now && !(selected && sck_rise && bit_cnt_r == BIT_CNT_LAST && dc_sync_r[1] == KIND_COMMAND)
         |=> $stable(cmd_reg_r);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command register changed without a byte");

   property p_deselect_count;
      @(posedge mclk_i) disable iff (!rst_n)
      !selected |=> bit_cnt_r == BIT_CNT_RST;
   endproperty
   a_deselect_count: assert property (p_deselect_count) else $error("partial byte kept");

   property p_mid_byte_quiet;
      @(posedge mclk_i) disable iff (!rst_n)
      bit_cnt_r != BIT_CNT_LAST |=> !data_stb_r && !cmd_stb_r;
   endproperty
   a_mid_byte_quiet: assert property (p_mid_byte_quiet) else $error("strobe before eighth bit");

   property p_init_flag;
      @(posedge mclk_i) disable iff (!rst_n)
      init_now |=> init_active_o;
   endproperty
   a_init_flag: assert property (p_init_flag) else $error("init flag missing");

   property p_init_flag_off;
      @(posedge mclk_i) disable iff (!rst_n)
      !init_now |=> !init_active_o;
   endproperty
   a_init_flag_off: assert property (p_init_flag_off) else $error("init flag stuck");

   property p_addr_hold;
      @(posedge mclk_i) disable iff (!rst_n)
      !mode_sync_r[1] |=> $stable(target_addr_lsb_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address bit moved outside two-wire mode");

   property p_idle_no_shift;
      @(posedge mclk_i) disable iff (!rst_n)
      !init_now && !(selected && sck_rise) |=> $stable(shift_r);
   endproperty
   a_idle_no_shift: assert property (p_idle_no_shift) else $error("shift without clock edge");
endmodule

// >>> testbench/host_model.sv
// Purpose: Host controller model for the display serial port
// Assumes: Link clock idles low and stands still between frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module host_model
(
   input  wire logic mclk_i,
   output logic      sel_n_o,
   output logic      dc_o,
   output logic      sck_o,
   output logic      mosi_o
);
   initial
   begin
      sel_n_o = 1'b1;
      dc_o = 1'b0;
      sck_o = 1'b0;
      mosi_o = 1'b0;
   end
   // Sends the top n bits of b; sel low keeps the port deselected
   task automatic send(input logic [7:0] b, input logic dc, input int n, input logic sel);
      @(posedge mclk_i);
      #1;
      dc_o = dc;
      sel_n_o = ~sel;
      for (int i = 7; i > 7 - n; i--)
      begin
         mosi_o = b[i];
         #400 sck_o = 1'b1;
         #400 sck_o = 1'b0;
      end
      #400 sel_n_o = 1'b1;
      mosi_o = ~mosi_o;
   endtask
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the display serial port
// Assumes: Host model drives all link pins
// Notes:   Strobes are counted so each pulse length is checked
`timescale 1ns/1ps
module tb_top;
   import disp_port_pkg::*;
   logic       mclk_i, reset_n_i, init_n, two_w, sel_n, dc, sck, mosi;
   logic [7:0] dreg, creg;
   logic       dstb, cstb, alsb, iact;
   int         err_count = 0;
   int         compares = 0;
   int         dcnt = 0;
   int         ccnt = 0;
   display_serial_host_port display_serial_host_port_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .init_pulse_n_i(init_n), .select_n_i(sel_n), .data_cmd_i(dc), .bus_line_zero_i(sck),
      .bus_line_one_i(mosi), .two_wire_mode_i(two_w), .data_reg_o(dreg), .data_strobe_o(dstb),
      .command_reg_o(creg), .command_strobe_o(cstb), .target_addr_lsb_o(alsb), .init_active_o(iact));
   host_model host_model_i (.mclk_i(mclk_i), .sel_n_o(sel_n), .dc_o(dc), .sck_o(sck), .mosi_o(mosi));
   always @(posedge mclk_i)
   begin
      dcnt <= dcnt + int'(dstb === 1'b1);
      ccnt <= ccnt + int'(cstb === 1'b1);
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_data;
      host_model_i.send(8'ha5, KIND_DATA, 8, 1'b1);
      chk(8'(dcnt), 8'h01);
      chk(8'(ccnt), 8'h00);
      chk(dreg, 8'ha5);
   endtask
   task automatic t_cmd;
      host_model_i.send(8'h3c, KIND_COMMAND, 8, 1'b1);
      chk(8'(ccnt), 8'h01);
      chk(creg, 8'h3c);
      chk(dreg, 8'ha5);
      chk(8'(dcnt), 8'h01);
   endtask
   task automatic t_abort;
      host_model_i.send(8'hff, KIND_DATA, 5, 1'b1);
      host_model_i.send(8'h81, KIND_DATA, 8, 1'b1);
      chk(8'(dcnt), 8'h02);
      chk(dreg, 8'h81);
   endtask
   task automatic t_ignore;
      host_model_i.send(8'h5a, KIND_DATA, 8, 1'b0);
      chk(8'(dcnt), 8'h02);
      chk(8'(ccnt), 8'h01);
      chk(dreg, 8'h81);
   endtask
   task automatic t_init;
      int k;
      @(posedge mclk_i);
      #1 init_n = 1'b0;
      for (k = 0; k < 20 && iact !== 1'b1; k++)
      begin
         @(posedge mclk_i);
         #1;
      end
      chk({7'h00, iact}, 8'h01);
      chk(dreg, BYTE_RST);
      chk(creg, BYTE_RST);
      init_n = 1'b1;
      repeat (4) @(posedge mclk_i);
      #1;
      chk({7'h00, iact}, 8'h00);
   endtask
   task automatic t_addr;
      two_w = 1'b1;
      host_model_i.send(8'hff, 1'b1, 8, 1'b1);
      chk({7'h00, alsb}, 8'h01);
      chk(8'(dcnt), 8'h02);
      host_model_i.send(8'h00, 1'b0, 0, 1'b0);
      repeat (4) @(posedge mclk_i);
      #1;
      chk({7'h00, alsb}, 8'h00);
      two_w = 1'b0;
      host_model_i.send(8'h00, 1'b1, 0, 1'b0);
      repeat (4) @(posedge mclk_i);
      #1;
      chk({7'h00, alsb}, 8'h00);
   endtask
   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   initial
   begin
      reset_n_i = 1'b0;
      init_n = 1'b1;
      two_w = 1'b0;
      repeat (5) @(posedge mclk_i);
      #1 reset_n_i = 1'b1;
      repeat (8) @(posedge mclk_i);
      t_data;
      t_cmd;
      t_abort;
      t_ignore;
      t_init;
      t_addr;
      summarize;
   end
endmodule
